// ==== logic/swbc_pkg.sv ====
// swbc_pkg: shared constants and types of the write burst controller
// Overview of operation
// [R1] writes run as fixed eight-beat, fixed four-beat chop, or per-command
// [R2] per-command mode: a12 low gives four-beat chop, high eight beats
// [R3] write with a10 low leaves the addressed bank open afterwards
// [R4] write with a10 high closes the bank by itself after the burst
// [R5] masking exists on x8 and x16 only, never on x4
// [R6] one pin per lane carries mask or inversion, as configured
// [R7] masking and bus inversion are exclusive; inversion wins if both set
// [R8] mask pin low on a lane during a beat discards that lane
// [R9] mask pin high on a lane stores that lane's data
// [R10] with checksum on, mask enable picks persistent, else nonpersistent
// [R11] write latency is added latency plus write command latency
// [R12] burst field 00 fixed eight beats, 01 per-command selection
// [R13] burst field 10 fixed four-beat chop for every write
// [R14] controller times recovery from the edge after the last data beat
// [R15] controller avoids command latency 9 with the two-clock preamble
// [R16] a chopped write stores only the first four beats
package swbc_pkg;
  // register byte offsets
  localparam logic [11:0] OFS_CTRL = 12'h000;
  localparam logic [11:0] OFS_LATENCY = 12'h004;
  localparam logic [11:0] OFS_STATUS = 12'h008;
  localparam logic [11:0] OFS_WRCOUNT = 12'h00C;
  localparam logic [11:0] OFS_MEMADDR = 12'h010;
  localparam logic [11:0] OFS_MEMDATA = 12'h014;
  // control register fields
  localparam int unsigned CTRL_BURST_LSB = 0;
  localparam int unsigned CTRL_MASK_BIT = 2;
  localparam int unsigned CTRL_INV_BIT = 3;
  localparam int unsigned CTRL_CRC_BIT = 4;
  localparam int unsigned CTRL_W = 5;
  localparam logic [4:0] CTRL_RST = 5'h00;
  // latency register fields
  localparam int unsigned LAT_AL_LSB = 0;
  localparam int unsigned LAT_CWL_LSB = 8;
  localparam int unsigned LAT_WL_LSB = 16;
  localparam int unsigned LAT_FW = 5;
  localparam logic [4:0] AL_RST = 5'h00;
  localparam logic [4:0] CWL_RST = 5'h09;
  // status register fields
  localparam int unsigned ST_BANK_LSB = 0;
  localparam int unsigned ST_CRCP_BIT = 8;
  localparam int unsigned ST_MASK_BIT = 9;
  localparam int unsigned ST_INV_BIT = 10;
  localparam int unsigned ST_CONF_BIT = 11;
  // index of the last beat pair of a burst, two beats per link clock
  localparam logic [1:0] PAIR_LAST_FULL = 2'h3;
  localparam logic [1:0] PAIR_LAST_CHOP = 2'h1;
  localparam int unsigned WRCOUNT_W = 16;
  typedef enum logic [1:0] {
    SWBC_BURST_FIXED8 = 2'b00,
    SWBC_BURST_PERCMD = 2'b01,
    SWBC_BURST_CHOP = 2'b10,
    SWBC_BURST_RSVD = 2'b11
  } swbc_burst_t;
  typedef enum logic [1:0] {
    SWBC_AP_IDLE = 2'b00,
    SWBC_AP_FETCH = 2'b01,
    SWBC_AP_RESP = 2'b10
  } swbc_apb_st_t;
  typedef enum logic {
    SWBC_WB_IDLE = 1'b0,
    SWBC_WB_BURST = 1'b1
  } swbc_wb_st_t;
endpackage

// ==== logic/swbc_sync.sv ====
// swbc_sync: two flip-flop level synchroniser
`timescale 1ns/10ps
`default_nettype none
module swbc_sync #(
  parameter int unsigned W = 1
) (
  input wire logic clk, // destination clock
  input wire logic rst_n, // async reset, active low
  input wire logic [W-1:0] d, // level from the other domain
  output logic [W-1:0] q // synchronised level
);
  logic [W-1:0] s1_q;
  logic [W-1:0] s2_q;

  if (W < 1) begin : g_chk
    $error("swbc_sync: width must be at least one");
  end

  // first stage is read by the second stage only
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s1_q <= '0;
      s2_q <= '0;
    end else begin
      s1_q <= d;
      s2_q <= s1_q;
    end
  end

  assign q = s2_q;
endmodule
`default_nettype wire

// ==== logic/swbc_delay_line.sv ====
// swbc_delay_line: shift register of pending writes with a selectable tap
`timescale 1ns/10ps
`default_nettype none
module swbc_delay_line #(
  parameter int unsigned W = 8,
  parameter int unsigned DEPTH = 64,
  localparam int unsigned TW = $clog2(DEPTH)
) (
  input wire logic clk, // link clock
  input wire logic rst_n, // async reset, active low
  input wire logic [W-1:0] din, // entry pushed every cycle
  input wire logic [TW-1:0] tap, // delay minus one, in cycles
  output logic [W-1:0] dout // entry delayed by tap plus one
);
  logic [W-1:0] sr_q [DEPTH];

  if (DEPTH < 2) begin : g_chk
    $error("swbc_delay_line: depth must be at least two");
  end

  // every stage cleared so no stale valid bit can fire after reset
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < DEPTH; i++) begin
        sr_q[i] <= '0;
      end
    end else begin
      sr_q[0] <= din;
      for (int i = 1; i < DEPTH; i++) begin
        sr_q[i] <= sr_q[i-1];
      end
    end
  end

  // tap beyond the depth is refused by the caller's elaboration check
  assign dout = sr_q[tap];
endmodule
`default_nettype wire

// ==== logic/swbc_write_burst.sv ====
// swbc_write_burst: write burst engine with apb configuration and array
`timescale 1ns/10ps
`default_nettype none
module swbc_write_burst #(
  parameter int unsigned DQW = 16,
  parameter int unsigned BANK_W = 2,
  parameter int unsigned COLW = 5,
  parameter int unsigned WL_DEPTH = 64,
  localparam int unsigned LANES = (DQW == 4) ? 1 : DQW / 8,
  localparam int unsigned BANKS = 1 << BANK_W
) (
  input wire logic pclk, // apb clock
  input wire logic presetn, // async reset, active low
  input wire logic [11:0] paddr, // apb byte address
  input wire logic psel, // apb select
  input wire logic penable, // apb access phase
  input wire logic pwrite, // apb direction, high for write
  input wire logic [31:0] pwdata, // apb write data
  output logic [31:0] prdata, // apb read data
  output logic pready, // apb ready
  output logic pslverr, // apb error, unmapped address
  input wire logic link_clk, // device clock from the controller
  input wire logic cmd_write, // write command this clock
  input wire logic cmd_activate, // activate command this clock
  input wire logic addr_a10, // auto close select
  input wire logic addr_a12, // per-command burst select
  input wire logic [BANK_W-1:0] bank_addr, // bank of the command
  input wire logic [COLW-1:0] col_addr, // column of the command
  input wire logic [2*DQW-1:0] dq_pair, // two beats, first beat low
  input wire logic [2*LANES-1:0] mask_inv_low_pair, // shared lane pins
  output logic precharge_start, // one link cycle, bank starts closing
  output logic [BANK_W-1:0] precharge_bank // bank that closes
);
  localparam int unsigned LW = (DQW == 4) ? 4 : 8;
  localparam int unsigned MAW = BANK_W + COLW;
  localparam int unsigned CHW = COLW - 3;
  localparam int unsigned TW = $clog2(WL_DEPTH);
  localparam int unsigned PW = 2 + 2 + BANK_W + COLW + 2*DQW + 2*LANES;
  localparam int unsigned DLW = 3 + BANK_W + CHW;
  localparam int unsigned CFGW = swbc_pkg::CTRL_W + 2*swbc_pkg::LAT_FW;
  // x4 parts have no lane function on the shared pin
  localparam bit MASK_OK = (DQW != 4);

  if (!(DQW == 4 || DQW == 8 || DQW == 16)) begin : g_chk_dqw
    $error("swbc_write_burst: DQW must be 4, 8 or 16");
  end
  if (COLW < 4 || WL_DEPTH < 62) begin : g_chk_geo
    $error("swbc_write_burst: COLW below 4 or WL_DEPTH below 62");
  end

  // one-hot register select, used by read mux, writes and fetch
  function automatic logic [5:0] reg_sel(input logic [11:0] a);
    logic [5:0] s;
    s = 6'h00;
    s[0] = (a == swbc_pkg::OFS_CTRL);
    s[1] = (a == swbc_pkg::OFS_LATENCY);
    s[2] = (a == swbc_pkg::OFS_STATUS);
    s[3] = (a == swbc_pkg::OFS_WRCOUNT);
    s[4] = (a == swbc_pkg::OFS_MEMADDR);
    s[5] = (a == swbc_pkg::OFS_MEMDATA);
    return s;
  endfunction

  // [R5] x4 masking absent
  // [R7] exclusion, inversion wins
  function automatic logic mask_on(input logic [4:0] c);
    return MASK_OK && c[swbc_pkg::CTRL_MASK_BIT] &&
           !c[swbc_pkg::CTRL_INV_BIT];
  endfunction

  // [R6] pin serves inversion
  function automatic logic inv_on(input logic [4:0] c);
    return MASK_OK && c[swbc_pkg::CTRL_INV_BIT];
  endfunction

  // [R12] [R13] burst field decode
  // [R2] a12 picks length
  function automatic logic chop_sel(input logic [1:0] m, input logic a12);
    logic r;
    r = 1'b0;
    case (m)
      swbc_pkg::SWBC_BURST_FIXED8: r = 1'b0;
      swbc_pkg::SWBC_BURST_PERCMD: r = !a12;
      swbc_pkg::SWBC_BURST_CHOP: r = 1'b1;
      default: r = 1'b0;
    endcase
    return r;
  endfunction

  // ---------------- apb clock domain ----------------
  logic [4:0] ctrl_q;
  logic [4:0] al_q;
  logic [4:0] cwl_q;
  logic [MAW-1:0] memaddr_q;
  logic [swbc_pkg::WRCOUNT_W-1:0] wcount_q;
  logic req_q;
  logic done_d_q;
  swbc_pkg::swbc_apb_st_t ap_st_q;
  logic [31:0] prdata_q;
  logic pready_q;
  logic pslverr_q;
  logic [31:0] rdata;
  logic [5:0] sel;
  logic wr_fire;
  logic ack_s;
  logic done_s;
  logic [BANKS-1:0] bank_s;
  logic [DQW-1:0] rd_link_q;

  assign sel = reg_sel(paddr);
  // writes land on the edge at which the master sees pready high
  assign wr_fire = (ap_st_q == swbc_pkg::SWBC_AP_RESP) && psel &&
                   penable && pwrite;

  // read data mux over all mapped registers except memdata, which is fetched
  always_comb begin
    rdata = 32'h0000_0000;
    if (sel[0]) begin
      rdata[swbc_pkg::CTRL_W-1:0] = ctrl_q;
    end
    if (sel[1]) begin
      rdata[swbc_pkg::LAT_AL_LSB +: swbc_pkg::LAT_FW] = al_q;
      rdata[swbc_pkg::LAT_CWL_LSB +: swbc_pkg::LAT_FW] = cwl_q;
      // [R11] latency sum shown
      rdata[swbc_pkg::LAT_WL_LSB +: 6] = {1'b0, al_q} + {1'b0, cwl_q};
    end
    if (sel[2]) begin
      rdata[swbc_pkg::ST_BANK_LSB +: BANKS] = bank_s;
      // [R10] checksum mode select
      rdata[swbc_pkg::ST_CRCP_BIT] = ctrl_q[swbc_pkg::CTRL_CRC_BIT] &&
                                     mask_on(ctrl_q);
      rdata[swbc_pkg::ST_MASK_BIT] = mask_on(ctrl_q);
      rdata[swbc_pkg::ST_INV_BIT] = inv_on(ctrl_q);
      // [R7] conflict reported
      rdata[swbc_pkg::ST_CONF_BIT] = ctrl_q[swbc_pkg::CTRL_MASK_BIT] &&
                                     ctrl_q[swbc_pkg::CTRL_INV_BIT];
    end
    if (sel[3]) begin
      rdata[swbc_pkg::WRCOUNT_W-1:0] = wcount_q;
    end
    if (sel[4]) begin
      rdata[MAW-1:0] = memaddr_q;
    end
  end

  // apb handshake; array reads wait for the link-side fetch
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ap_st_q <= swbc_pkg::SWBC_AP_IDLE;
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h0000_0000;
      req_q <= 1'b0;
    end else begin
      case (ap_st_q)
        swbc_pkg::SWBC_AP_IDLE: begin
          if (psel && penable) begin
            if (!pwrite && sel[5]) begin
              req_q <= !req_q;
              ap_st_q <= swbc_pkg::SWBC_AP_FETCH;
            end else begin
              pready_q <= 1'b1;
              pslverr_q <= (sel == 6'h00);
              prdata_q <= pwrite ? 32'h0000_0000 : rdata;
              ap_st_q <= swbc_pkg::SWBC_AP_RESP;
            end
          end
        end
        swbc_pkg::SWBC_AP_FETCH: begin
          // ack equal to req means the link word is stable
          if (ack_s == req_q) begin
            pready_q <= 1'b1;
            prdata_q <= 32'(rd_link_q);
            ap_st_q <= swbc_pkg::SWBC_AP_RESP;
          end
        end
        swbc_pkg::SWBC_AP_RESP: begin
          pready_q <= 1'b0;
          pslverr_q <= 1'b0;
          ap_st_q <= swbc_pkg::SWBC_AP_IDLE;
        end
        default: begin
          pready_q <= 1'b0;
          pslverr_q <= 1'b0;
          ap_st_q <= swbc_pkg::SWBC_AP_IDLE;
        end
      endcase
    end
  end

  // configuration registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= swbc_pkg::CTRL_RST;
      al_q <= swbc_pkg::AL_RST;
      cwl_q <= swbc_pkg::CWL_RST;
      memaddr_q <= '0;
    end else if (wr_fire) begin
      if (sel[0]) begin
        ctrl_q <= pwdata[swbc_pkg::CTRL_W-1:0];
      end
      if (sel[1]) begin
        al_q <= pwdata[swbc_pkg::LAT_AL_LSB +: swbc_pkg::LAT_FW];
        cwl_q <= pwdata[swbc_pkg::LAT_CWL_LSB +: swbc_pkg::LAT_FW];
      end
      if (sel[4]) begin
        memaddr_q <= pwdata[MAW-1:0];
      end
    end
  end

  // completed bursts counted from the link toggle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      done_d_q <= 1'b0;
      wcount_q <= '0;
    end else begin
      done_d_q <= done_s;
      if (done_s != done_d_q) begin
        wcount_q <= wcount_q + 16'h0001;
      end
    end
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;

  // ---------------- link clock domain ----------------
  logic lrst_n;
  logic [PW-1:0] pin_s1_q;
  logic [PW-1:0] pin_s2_q;
  logic [CFGW-1:0] cfg_l;
  logic [4:0] ctrl_l;
  logic [5:0] wl_l;
  logic [TW-1:0] tap_l;
  logic l_wr;
  logic l_act;
  logic l_a10;
  logic l_a12;
  logic [BANK_W-1:0] l_bank;
  logic [COLW-1:0] l_col;
  logic [2*DQW-1:0] l_dq;
  logic [2*LANES-1:0] l_pin;
  logic [DLW-1:0] dl_in;
  logic [DLW-1:0] dl_out;
  swbc_pkg::swbc_wb_st_t wb_st_q;
  logic [1:0] cnt_q;
  logic hold_chop_q;
  logic hold_a10_q;
  logic [BANK_W-1:0] hold_bank_q;
  logic [CHW-1:0] hold_ch_q;
  logic cur_v;
  logic cur_chop;
  logic cur_a10;
  logic [BANK_W-1:0] cur_bank;
  logic [CHW-1:0] cur_ch;
  logic [1:0] cur_pair;
  logic burst_end;
  logic [BANKS-1:0] bank_open_q;
  logic done_tg_q;
  logic precharge_start_q;
  logic [BANK_W-1:0] precharge_bank_q;
  logic rq_s;
  logic rq_d_q;
  logic ack_q;
  logic [DQW-1:0] wdat [2];
  logic [LANES-1:0] wen [2];
  logic [DQW-1:0] mem_q [2**MAW];

  // reset released in step with the link clock
  swbc_sync #(.W(1)) u_lrst (
    .clk(link_clk),
    .rst_n(presetn),
    .d(1'b1),
    .q(lrst_n)
  );

  // configuration held still by software while writes run
  swbc_sync #(.W(CFGW)) u_cfg (
    .clk(link_clk),
    .rst_n(lrst_n),
    .d({ctrl_q, al_q, cwl_q}),
    .q(cfg_l)
  );

  swbc_sync #(.W(1)) u_req (
    .clk(link_clk),
    .rst_n(lrst_n),
    .d(req_q),
    .q(rq_s)
  );

  swbc_sync #(.W(1)) u_ack (
    .clk(pclk),
    .rst_n(presetn),
    .d(ack_q),
    .q(ack_s)
  );

  swbc_sync #(.W(1)) u_done (
    .clk(pclk),
    .rst_n(presetn),
    .d(done_tg_q),
    .q(done_s)
  );

  swbc_sync #(.W(BANKS)) u_bank (
    .clk(pclk),
    .rst_n(presetn),
    .d(bank_open_q),
    .q(bank_s)
  );

  // pins pass two stages together, so relative timing is kept
  always_ff @(posedge link_clk or negedge lrst_n) begin
    if (!lrst_n) begin
      pin_s1_q <= '0;
      pin_s2_q <= '0;
    end else begin
      pin_s1_q <= {cmd_write, cmd_activate, addr_a10, addr_a12, bank_addr,
                   col_addr, dq_pair, mask_inv_low_pair};
      pin_s2_q <= pin_s1_q;
    end
  end

  assign {l_wr, l_act, l_a10, l_a12, l_bank, l_col, l_dq, l_pin} = pin_s2_q;
  assign ctrl_l = cfg_l[CFGW-1 -: swbc_pkg::CTRL_W];
  // [R11] latency is sum
  assign wl_l = {1'b0, cfg_l[2*swbc_pkg::LAT_FW-1 -: swbc_pkg::LAT_FW]} +
                {1'b0, cfg_l[swbc_pkg::LAT_FW-1:0]};
  // a zero latency setting behaves as one
  assign tap_l = (wl_l == 6'h00) ? '0 : TW'(wl_l - 6'h01);
  // [R1] [R2] length fixed at command
  assign dl_in = {l_wr, chop_sel(ctrl_l[1:0], l_a12), l_a10, l_bank,
                  l_col[COLW-1:3]};

  swbc_delay_line #(.W(DLW), .DEPTH(WL_DEPTH)) u_wl (
    .clk(link_clk),
    .rst_n(lrst_n),
    .din(dl_in),
    .tap(tap_l),
    .dout(dl_out)
  );

  // a newly due command takes over from a running burst
  always_comb begin
    cur_v = dl_out[DLW-1] || (wb_st_q == swbc_pkg::SWBC_WB_BURST);
    if (dl_out[DLW-1]) begin
      {cur_chop, cur_a10, cur_bank, cur_ch} = dl_out[DLW-2:0];
      cur_pair = 2'h0;
    end else begin
      cur_chop = hold_chop_q;
      cur_a10 = hold_a10_q;
      cur_bank = hold_bank_q;
      cur_ch = hold_ch_q;
      cur_pair = cnt_q;
    end
    // [R16] chop ends after four beats
    burst_end = cur_v && (cur_pair == (cur_chop ?
                swbc_pkg::PAIR_LAST_CHOP : swbc_pkg::PAIR_LAST_FULL));
  end

  // beat tracking across the burst
  always_ff @(posedge link_clk or negedge lrst_n) begin
    if (!lrst_n) begin
      wb_st_q <= swbc_pkg::SWBC_WB_IDLE;
      cnt_q <= 2'h0;
      hold_chop_q <= 1'b0;
      hold_a10_q <= 1'b0;
      hold_bank_q <= '0;
      hold_ch_q <= '0;
    end else begin
      case (wb_st_q)
        swbc_pkg::SWBC_WB_IDLE,
        swbc_pkg::SWBC_WB_BURST: begin
          if (burst_end || !cur_v) begin
            wb_st_q <= swbc_pkg::SWBC_WB_IDLE;
          end else begin
            wb_st_q <= swbc_pkg::SWBC_WB_BURST;
            cnt_q <= cur_pair + 2'h1;
            hold_chop_q <= cur_chop;
            hold_a10_q <= cur_a10;
            hold_bank_q <= cur_bank;
            hold_ch_q <= cur_ch;
          end
        end
        default: begin
          wb_st_q <= swbc_pkg::SWBC_WB_IDLE;
        end
      endcase
    end
  end

  // lane data and enables for both beats of the pair
  always_comb begin
    for (int b = 0; b < 2; b++) begin
      wdat[b] = l_dq[b*DQW +: DQW];
      wen[b] = '1;
      for (int l = 0; l < LANES; l++) begin
        // [R6] pin read as inversion
        if (inv_on(ctrl_l) && !l_pin[b*LANES + l]) begin
          wdat[b][l*LW +: LW] = ~l_dq[b*DQW + l*LW +: LW];
        end
        // [R8] low pin masks lane
        // [R9] high pin stores lane
        wen[b][l] = !(mask_on(ctrl_l) && !l_pin[b*LANES + l]);
      end
    end
  end

  // array write; masked lanes keep their stored bytes
  always_ff @(posedge link_clk) begin
    if (cur_v) begin
      for (int b = 0; b < 2; b++) begin
        for (int l = 0; l < LANES; l++) begin
          if (wen[b][l]) begin
            mem_q[{cur_bank, cur_ch, cur_pair, b[0]}][l*LW +: LW] <=
              wdat[b][l*LW +: LW];
          end
        end
      end
    end
  end

  // bank state, auto close and burst completion toggle
  always_ff @(posedge link_clk or negedge lrst_n) begin
    if (!lrst_n) begin
      bank_open_q <= '0;
      done_tg_q <= 1'b0;
      precharge_start_q <= 1'b0;
      precharge_bank_q <= '0;
    end else begin
      precharge_start_q <= 1'b0;
      if (burst_end) begin
        done_tg_q <= !done_tg_q;
        // [R3] a10 low stays open
        // [R4] a10 high closes bank
        if (cur_a10) begin
          bank_open_q[cur_bank] <= 1'b0;
          precharge_start_q <= 1'b1;
          precharge_bank_q <= cur_bank;
        end
      end
      if (l_act) begin
        bank_open_q[l_bank] <= 1'b1;
      end
    end
  end

  // array fetch for apb; memaddr is still while req is pending
  always_ff @(posedge link_clk or negedge lrst_n) begin
    if (!lrst_n) begin
      rq_d_q <= 1'b0;
      ack_q <= 1'b0;
      rd_link_q <= '0;
    end else begin
      rq_d_q <= rq_s;
      if (rq_s != rq_d_q) begin
        rd_link_q <= mem_q[memaddr_q];
        ack_q <= rq_s;
      end
    end
  end

  assign precharge_start = precharge_start_q;
  assign precharge_bank = precharge_bank_q;
endmodule
`default_nettype wire

// ==== test/swbc_write_burst_checker.sv ====
// assertion checker of the write burst controller ports
`timescale 1ns/10ps
`default_nettype none
module swbc_write_burst_checker #(
  parameter int unsigned BANK_W = 2
) (
  input wire logic pclk, // apb clock
  input wire logic presetn, // async reset
  input wire logic [11:0] paddr, // address
  input wire logic psel, // select
  input wire logic penable, // access phase
  input wire logic [31:0] prdata, // read data
  input wire logic pready, // ready
  input wire logic pslverr, // error
  input wire logic link_clk, // link clock
  input wire logic cmd_write, // write command
  input wire logic addr_a10, // auto close
  input wire logic [BANK_W-1:0] bank_addr, // command bank
  input wire logic precharge_start, // close pulse
  input wire logic [BANK_W-1:0] precharge_bank // closing bank
);
  logic [7:0] cnt_q;
  logic armed_q;
  logic [BANK_W-1:0] bk_q;
  // age of last write command; saturates so it never wraps
  always_ff @(posedge link_clk or negedge presetn) begin
    if (!presetn) begin
      cnt_q <= 8'hFF;
      armed_q <= 1'b0;
      bk_q <= '0;
    end else if (cmd_write) begin
      cnt_q <= 8'h00;
      armed_q <= addr_a10;
      bk_q <= bank_addr;
    end else if (cnt_q != 8'hFF) begin
      cnt_q <= cnt_q + 8'h01;
    end
  end
  sequence acc_first;
    psel && penable && !$past(penable);
  endsequence
  sequence reg_access;
    acc_first ##0 (paddr != swbc_pkg::OFS_MEMDATA);
  endsequence
  ready_pulse_a: assert property (@(posedge pclk) disable iff (!presetn)
    pready |=> !pready) else $error("ready too long");
  ready_access_a: assert property (@(posedge pclk) disable iff (!presetn)
    pready |-> psel && penable) else $error("ready outside access");
  ready_wait_a: assert property (@(posedge pclk) disable iff (!presetn)
    acc_first |-> !pready) else $error("ready too early");
  reg_answer_a: assert property (@(posedge pclk) disable iff (!presetn)
    reg_access |=> pready) else $error("register answer late");
  err_zero_a: assert property (@(posedge pclk) disable iff (!presetn)
    pslverr |-> pready && prdata == 32'h0) else $error("bad error answer");
  data_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
    $changed(prdata) |-> pready) else $error("read data moved");
  close_pulse_a: assert property (@(posedge link_clk)
    disable iff (!presetn) precharge_start |=> !precharge_start)
    else $error("close pulse too long");
  close_cause_a: assert property (@(posedge link_clk)
    disable iff (!presetn) precharge_start |-> armed_q &&
    cnt_q >= 8'h04 && cnt_q <= 8'h43) else $error("close without cause");
  close_bank_a: assert property (@(posedge link_clk)
    disable iff (!presetn) precharge_start |-> precharge_bank == bk_q)
    else $error("wrong bank closed");
  bank_hold_a: assert property (@(posedge link_clk)
    disable iff (!presetn) $changed(precharge_bank) |-> precharge_start)
    else $error("close bank moved");
endmodule
bind swbc_write_burst swbc_write_burst_checker #(.BANK_W(BANK_W)) i_chk (.*);
`default_nettype wire

// ==== test/swbc_host_model.sv ====
// memory controller model issuing commands and write data
`timescale 1ns/10ps
`default_nettype none
module swbc_host_model (
  input wire logic link_clk, // device clock
  output logic cmd_write, // write command
  output logic cmd_activate, // activate command
  output logic addr_a10, // auto close
  output logic addr_a12, // burst select
  output logic [1:0] bank_addr, // bank
  output logic [4:0] col_addr, // column
  output logic [31:0] dq_pair, // two beats
  output logic [3:0] mask_inv_low_pair // lane pins
);
  // idle bus at time zero
  initial begin
    {cmd_write, cmd_activate, addr_a10, addr_a12, bank_addr} = 6'h00;
    {col_addr, dq_pair, mask_inv_low_pair} = 41'h0;
  end
  // open one bank for a single link cycle
  task automatic act(input logic [1:0] bk);
    @(posedge link_clk);
    cmd_activate <= 1'b1;
    bank_addr <= bk;
    @(posedge link_clk);
    cmd_activate <= 1'b0;
  endtask
  // command, then pairs one write latency later
  task automatic wr(input logic a10, a12, input logic [1:0] bk,
    input logic [4:0] col, input logic [127:0] d, input logic [15:0] m,
    input int wl);
    @(posedge link_clk);
    cmd_write <= 1'b1;
    {addr_a10, addr_a12, bank_addr, col_addr} <= {a10, a12, bk, col};
    @(posedge link_clk);
    cmd_write <= 1'b0;
    {addr_a10, addr_a12} <= {~a10, ~a12};
    repeat (wl - 1) @(posedge link_clk);
    for (int k = 0; k < 4; k++) begin
      dq_pair <= d[32*k+:32];
      mask_inv_low_pair <= m[4*k+:4];
      @(posedge link_clk);
    end
    // released lines show the inverse
    dq_pair <= ~dq_pair;
    mask_inv_low_pair <= ~mask_inv_low_pair;
    // recovery from the edge after the last beat
    repeat (4) @(posedge link_clk);
  endtask
endmodule
`default_nettype wire

// ==== test/swbc_write_burst_bench.sv ====
// self-checking bench of the write burst controller
`timescale 1ns/10ps
`default_nettype none
module swbc_write_burst_bench;
  logic pclk = 1'b0, link_clk = 1'b0, presetn = 1'b0, psel = 1'b0;
  logic penable = 1'b0, pwrite = 1'b0, pready, pslverr, precharge_start;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata;
  logic cmd_write, cmd_activate, addr_a10, addr_a12;
  logic [1:0] bank_addr, precharge_bank;
  logic [4:0] col_addr;
  logic [31:0] dq_pair;
  logic [3:0] mask_inv_low_pair;
  logic [31:0] seed = 32'h0000_BA30;
  logic [15:0] mem [128];
  int mismatches = 0, total_checks = 0, wl = 9, nb = 0;
  always #10 pclk = ~pclk;
  // link clock with its own phase
  initial begin
    #3;
    forever #80 link_clk = ~link_clk;
  end
  swbc_write_burst i_swbc_write_burst (.*);
  swbc_host_model i_swbc_host_model (.*);
  // xorshift source, fixed start
  function logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  // lane result: inversion wins over masking
  function automatic logic [15:0] mix(input logic [15:0] o, n,
    input logic [1:0] p, input logic [4:0] c);
    mix = n;
    for (int l = 0; l < 2; l++)
      if (!p[l])
        mix[8*l+:8] = c[3] ? ~n[8*l+:8] : c[2] ? o[8*l+:8] : n[8*l+:8];
  endfunction
  task automatic conclude();
    if (mismatches == 0 && total_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, x);
    total_checks++;
    if (g !== x) begin
      mismatches++;
      $display("wrong value at %0t: got %h, expected %h", $time, g, x);
    end
  endtask
  // one apb transfer; holds the request until ready
  task automatic apb(input logic w, input logic [11:0] a,
    input logic [31:0] d, output logic [31:0] r, output logic e);
    int n = 0;
    @(posedge pclk);
    {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 2000);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 2000) begin
      mismatches++;
      conclude();
    end
  endtask
  task automatic rdc(input logic [11:0] a, input logic [31:0] k, x);
    logic [31:0] r;
    logic e;
    apb(1'b0, a, 32'h0, r, e);
    chk(r & k, x);
  endtask
  // configure, then one write burst checked word by word
  task automatic burst(input logic [4:0] c, input logic [1:0] bk,
    input logic [4:0] col);
    logic [127:0] d;
    logic [31:0] r;
    logic [6:0] base;
    logic e, chop;
    d = {rnd(), rnd(), rnd(), rnd()};
    base = {bk, col[4:3], 3'h0};
    apb(1'b1, swbc_pkg::OFS_CTRL, {27'h0, c}, r, e);
    r = rnd();
    repeat (4) @(posedge link_clk);
    rdc(swbc_pkg::OFS_STATUS, 32'hF00, {20'h0, c[2] & c[3], c[3],
      c[2] & ~c[3], c[4] & c[2] & ~c[3], 8'h0});
    i_swbc_host_model.act(bk);
    i_swbc_host_model.wr(r[0], r[1], bk, col, d, r[31:16], wl);
    nb++;
    chop = c[1:0] == 2'b10 || (c[1:0] == 2'b01 && !r[1]);
    // a chopped write keeps four beats only
    for (int j = 0; j < 8; j++)
      if (j < 4 || !chop)
        mem[base+j] = mix(mem[base+j], d[16*j+:16], r[16+2*j+:2], c);
    repeat (4) @(posedge link_clk);
    rdc(swbc_pkg::OFS_STATUS, 32'h1 << bk, r[0] ? 0 : 32'h1 << bk);
    if (r[0])
      chk({30'h0, precharge_bank}, {30'h0, bk});
    for (int j = 0; j < 8; j++) begin
      apb(1'b1, swbc_pkg::OFS_MEMADDR, {25'h0, base + 7'(j)}, r, e);
      rdc(swbc_pkg::OFS_MEMDATA, 32'hFFFF, {16'h0, mem[base+j]});
    end
  endtask
  // watchdog well beyond the expected run
  initial begin
    #800000;
    mismatches++;
    conclude();
  end
  initial begin
    logic [31:0] r;
    logic e;
    repeat (5) @(posedge link_clk);
    @(posedge pclk);
    presetn <= 1'b1;
    repeat (4) @(posedge link_clk);
    rdc(swbc_pkg::OFS_CTRL, 32'hFFFF_FFFF, 32'h0);
    rdc(swbc_pkg::OFS_LATENCY, 32'hFFFF_FFFF, 32'h0009_0900);
    // unmapped address refused, read-only write ignored
    apb(1'b0, 12'h018, 32'h0, r, e);
    chk({31'h0, e}, 32'h1);
    apb(1'b1, swbc_pkg::OFS_STATUS, 32'hFFFF_FFFF, r, e);
    rdc(swbc_pkg::OFS_STATUS, 32'hFFFF_FFFF, 32'h0);
    // every burst field, random modes, plain preload first
    for (int i = 0; i < 16; i++) begin
      if (i == 8) begin
        // one-clock preamble keeps latency 9 legal
        apb(1'b1, swbc_pkg::OFS_LATENCY, 32'h0000_090A, r, e);
        wl = 19;
        rdc(swbc_pkg::OFS_LATENCY, 32'hFFFF_FFFF, 32'h0013_090A);
      end
      r = rnd();
      burst(5'h00, r[1:0], r[6:2]);
      burst({r[12:10], 2'(i)}, r[1:0], r[6:2]);
    end
    rdc(swbc_pkg::OFS_WRCOUNT, 32'hFFFF, nb);
    conclude();
  end
endmodule
`default_nettype wire
